// file: pdm_load_model.sv
// partner model: external load on the modulator pin, counts level and edges
`timescale 1ns/1ps
module pdm_load_model (
  input  wire logic        sys_clk,
  input  wire logic        rst,
  input  wire logic        pin_o,
  input  wire logic        pin_oe,
  input  wire logic        clr,
  output logic             pin_level,
  output logic [31:0]      high_cnt,
  output logic [31:0]      rise_cnt
);
  // ----------------------------------------------------------------
  // pin level and counters
  // ----------------------------------------------------------------
  logic undriven_ff;
  logic prev_ff;

  // no pull on this pin: an undriven line wanders, never a clean level
  assign pin_level = pin_oe ? pin_o : undriven_ff;

  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      undriven_ff <= 1'b0;
      prev_ff     <= 1'b0;
      high_cnt    <= 32'h0;
      rise_cnt    <= 32'h0;
    end else begin
      undriven_ff <= ~undriven_ff;
      prev_ff     <= pin_level;
      high_cnt    <= clr ? 32'h0 : high_cnt + {31'h0, pin_level};
      rise_cnt    <= clr ? 32'h0 : rise_cnt + {31'h0, pin_level & ~prev_ff};
    end
  end
endmodule

// file: pdm_modulator.sv
// module: pulse density modulator with axi4-lite registers and pin mux
//
// Notes on behaviour
// R1 - the pin carries the modulator output when mux bit 4 is 1, else gpio.
// R2 - control bit 4 enables the modulator; at 0 it is held disabled.
// R3 - base clock is the main clock divided by 2 to the 3-bit selector.
// R4 - base clock yields 16 weighted pulses, pulse k at base/2^(16-k).
// R5 - density bit k includes weighted pulse k in the combined output.
// R6 - output duty equals density word over 65536, any word 0 to 65535.
// R7 - density word is held as high byte at 30h and low byte at 31h, r/w.
// R8 - for constant high, software returns the pin to gpio driven at 1.
// R9 - unimplemented bits of mux and control ignore writes and read 0.
// R10 - software enables, picks divider, loads word, sets direction, mux.
// R11 - weighted pulses sit in disjoint one-base-tick slots of a counter.
// R12 - a density bit of 1 includes its pulse, a 0 leaves it out.
//
// The AXI4-Lite slave port was decided locally.
`timescale 1ns/1ps
module pdm_modulator #(
  parameter int ADDR_W = 8
) (
  input  wire logic              sys_clk,
  input  wire logic              rst,
  input  wire logic [ADDR_W-1:0] s_axi_awaddr,
  input  wire logic [2:0]        s_axi_awprot,
  input  wire logic              s_axi_awvalid,
  output logic                   s_axi_awready,
  input  wire logic [31:0]       s_axi_wdata,
  input  wire logic [3:0]        s_axi_wstrb,
  input  wire logic              s_axi_wvalid,
  output logic                   s_axi_wready,
  output logic [1:0]             s_axi_bresp,
  output logic                   s_axi_bvalid,
  input  wire logic              s_axi_bready,
  input  wire logic [ADDR_W-1:0] s_axi_araddr,
  input  wire logic [2:0]        s_axi_arprot,
  input  wire logic              s_axi_arvalid,
  output logic                   s_axi_arready,
  output logic [31:0]            s_axi_rdata,
  output logic [1:0]             s_axi_rresp,
  output logic                   s_axi_rvalid,
  input  wire logic              s_axi_rready,
  input  wire logic              gpio_out_data,
  input  wire logic              port_two_direction,
  output logic                   gpio_in_data,
  input  wire logic              port_two_bit_two_pin_i,
  output logic                   port_two_bit_two_pin_o,
  output logic                   port_two_bit_two_pin_oe
);

  // the decoder compares 8-bit byte addresses with bits 1:0 ignored
  if (ADDR_W < 8) begin : g_addr_w_check
    $error("pdm_modulator: ADDR_W must be at least 8");
  end

  // ----------------------------------------------------------------
  // address decode
  // ----------------------------------------------------------------
  function automatic pdm_pkg::pdm_reg_t pdm_decode(
    input logic [ADDR_W-1:0] a
  );
    logic [ADDR_W-1:0] w;
    w = {a[ADDR_W-1:2], 2'b00};
    if (w == ADDR_W'(pdm_pkg::ADDR_MUX)) begin
      return pdm_pkg::PDM_REG_MUX;
    end else if (w == ADDR_W'(pdm_pkg::ADDR_DHI)) begin
      return pdm_pkg::PDM_REG_DHI;
    end else if (w == ADDR_W'(pdm_pkg::ADDR_DLO)) begin
      return pdm_pkg::PDM_REG_DLO;
    end else if (w == ADDR_W'(pdm_pkg::ADDR_CTL)) begin
      return pdm_pkg::PDM_REG_CTL;
    end else begin
      return pdm_pkg::PDM_REG_NONE;
    end
  endfunction

  // ----------------------------------------------------------------
  // write channel
  // ----------------------------------------------------------------
  logic              aw_got_ff;
  logic [ADDR_W-1:0] aw_addr_ff;
  logic              w_got_ff;
  logic [7:0]        w_data_ff;
  logic              w_strb_ff;
  logic              bvalid_ff;
  logic [1:0]        bresp_ff;
  logic              aw_take;
  logic              w_take;
  logic              wr_fire;
  logic [ADDR_W-1:0] wr_addr;
  logic [7:0]        wr_data;
  logic              wr_strb;
  pdm_pkg::pdm_reg_t wr_idx;

  assign s_axi_awready = !aw_got_ff && !bvalid_ff;
  assign s_axi_wready  = !w_got_ff && !bvalid_ff;
  assign aw_take = s_axi_awvalid && s_axi_awready;
  assign w_take  = s_axi_wvalid && s_axi_wready;
  assign wr_fire = (aw_got_ff || aw_take) && (w_got_ff || w_take);
  assign wr_addr = aw_take ? s_axi_awaddr : aw_addr_ff;
  assign wr_data = w_take ? s_axi_wdata[7:0] : w_data_ff;
  assign wr_strb = w_take ? s_axi_wstrb[0] : w_strb_ff;
  assign wr_idx  = pdm_decode(wr_addr);
  assign s_axi_bvalid = bvalid_ff;
  assign s_axi_bresp  = bresp_ff;

  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      aw_got_ff  <= 1'b0;
      aw_addr_ff <= '0;
      w_got_ff   <= 1'b0;
      w_data_ff  <= 8'h00;
      w_strb_ff  <= 1'b0;
      bvalid_ff  <= 1'b0;
      bresp_ff   <= pdm_pkg::RESP_OKAY;
    end else if (wr_fire) begin
      aw_got_ff <= 1'b0;
      w_got_ff  <= 1'b0;
      bvalid_ff <= 1'b1;
      bresp_ff  <= (wr_idx == pdm_pkg::PDM_REG_NONE) ?
                   pdm_pkg::RESP_SLVERR : pdm_pkg::RESP_OKAY;
    end else begin
      if (aw_take) begin
        aw_got_ff  <= 1'b1;
        aw_addr_ff <= s_axi_awaddr;
      end
      if (w_take) begin
        w_got_ff  <= 1'b1;
        w_data_ff <= s_axi_wdata[7:0];
        w_strb_ff <= s_axi_wstrb[0];
      end
      if (bvalid_ff && s_axi_bready) begin
        bvalid_ff <= 1'b0;
      end
    end
  end

  // ----------------------------------------------------------------
  // registers
  // ----------------------------------------------------------------
  logic                          pin_modulator_select_ff;
  logic [pdm_pkg::DENS_W-1:0]    density_word_ff;
  logic                          modulator_enable_ff;
  logic [pdm_pkg::SEL_W-1:0]     base_clock_divider_select_ff;
  logic                          wr_ok;

  // only byte lane 0 carries register data; other lanes are ignored
  assign wr_ok = wr_fire && wr_strb;

  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      pin_modulator_select_ff <= pdm_pkg::RST_MUX[pdm_pkg::MUX_SEL_BIT];
      density_word_ff         <= {pdm_pkg::RST_DHI, pdm_pkg::RST_DLO};
      modulator_enable_ff     <= pdm_pkg::RST_CTL[pdm_pkg::CTL_EN_BIT];
      base_clock_divider_select_ff <= pdm_pkg::RST_CTL[pdm_pkg::SEL_W-1:0];
    end else if (wr_ok) begin
      case (wr_idx)
        pdm_pkg::PDM_REG_MUX: begin
          pin_modulator_select_ff <= wr_data[pdm_pkg::MUX_SEL_BIT]; // R9
        end
        pdm_pkg::PDM_REG_DHI: begin
          density_word_ff[15:8] <= wr_data; // R7
        end
        pdm_pkg::PDM_REG_DLO: begin
          density_word_ff[7:0] <= wr_data; // R7
        end
        pdm_pkg::PDM_REG_CTL: begin
          modulator_enable_ff <= wr_data[pdm_pkg::CTL_EN_BIT]; // R9
          base_clock_divider_select_ff <= wr_data[pdm_pkg::SEL_W-1:0];
        end
        default: begin
        end
      endcase
    end
  end

  // ----------------------------------------------------------------
  // read channel
  // ----------------------------------------------------------------
  logic              rvalid_ff;
  logic [7:0]        rdata_ff;
  logic [1:0]        rresp_ff;
  logic              rd_fire;
  pdm_pkg::pdm_reg_t rd_idx;
  logic [7:0]        rd_byte;
  logic [7:0]        mux_view;
  logic [7:0]        ctl_view;

  assign s_axi_arready = !rvalid_ff;
  assign rd_fire = s_axi_arvalid && s_axi_arready;
  assign rd_idx  = pdm_decode(s_axi_araddr);
  // unimplemented positions are simply never stored, so they read 0
  assign mux_view = 8'(pin_modulator_select_ff) << pdm_pkg::MUX_SEL_BIT; // R9
  assign ctl_view = (8'(modulator_enable_ff) << pdm_pkg::CTL_EN_BIT) |
                    8'(base_clock_divider_select_ff); // R9
  assign rd_byte =
    (rd_idx == pdm_pkg::PDM_REG_MUX) ? mux_view :
    (rd_idx == pdm_pkg::PDM_REG_DHI) ? density_word_ff[15:8] :
    (rd_idx == pdm_pkg::PDM_REG_DLO) ? density_word_ff[7:0] :
    (rd_idx == pdm_pkg::PDM_REG_CTL) ? ctl_view : 8'h00;
  assign s_axi_rvalid = rvalid_ff;
  assign s_axi_rdata  = {24'h000000, rdata_ff};
  assign s_axi_rresp  = rresp_ff;

  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      rvalid_ff <= 1'b0;
      rdata_ff  <= 8'h00;
      rresp_ff  <= pdm_pkg::RESP_OKAY;
    end else if (rd_fire) begin
      rvalid_ff <= 1'b1;
      rdata_ff  <= rd_byte;
      rresp_ff  <= (rd_idx == pdm_pkg::PDM_REG_NONE) ?
                   pdm_pkg::RESP_SLVERR : pdm_pkg::RESP_OKAY;
    end else if (rvalid_ff && s_axi_rready) begin
      rvalid_ff <= 1'b0;
    end
  end

  // ----------------------------------------------------------------
  // base clock divider
  // ----------------------------------------------------------------
  // a tick enable, not a derived clock: avoids a second clock domain
  logic [pdm_pkg::PRE_W-1:0] presc_ff;
  logic [7:0]                sel_onehot;
  logic [pdm_pkg::PRE_W-1:0] div_mask;
  logic                      base_tick;

  assign sel_onehot = 8'h01 << base_clock_divider_select_ff;
  assign div_mask   = 7'(sel_onehot - 8'h01); // R3
  assign base_tick  = modulator_enable_ff &&
                      ((presc_ff & div_mask) == div_mask); // R3

  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      presc_ff <= '0;
    end else if (!modulator_enable_ff) begin
      presc_ff <= '0; // R2
    end else begin
      presc_ff <= presc_ff + 7'h01;
    end
  end

  // ----------------------------------------------------------------
  // weighted pulses and density output
  // ----------------------------------------------------------------
  logic [pdm_pkg::DENS_W-1:0] slot_cnt_ff;
  logic [pdm_pkg::DENS_W-1:0] pulse_vec;
  logic                       pdm_out_ff;
  logic                       nxt_pdm_out;

  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      slot_cnt_ff <= '0;
    end else if (!modulator_enable_ff) begin
      slot_cnt_ff <= '0; // R2
    end else if (base_tick) begin
      slot_cnt_ff <= slot_cnt_ff + 16'h0001; // R4
    end
  end

  // pulse k fires when counter bit 15-k is the lowest set bit
  for (genvar k = 0; k < pdm_pkg::DENS_W; k++) begin : g_pulse
    localparam logic [15:0] LOW_MASK = 16'((32'h1 << (15 - k)) - 1);
    assign pulse_vec[k] = slot_cnt_ff[15 - k] &&
                          ((slot_cnt_ff & LOW_MASK) == 16'h0000); // R11
  end

  // a set bit includes its pulse; all-ones still misses one slot
  assign nxt_pdm_out = modulator_enable_ff &&
                       |(density_word_ff & pulse_vec); // R5 R6 R12

  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      pdm_out_ff <= 1'b0;
    end else begin
      pdm_out_ff <= nxt_pdm_out;
    end
  end

  // ----------------------------------------------------------------
  // pin mux and input synchroniser
  // ----------------------------------------------------------------
  logic                             pin_o_ff;
  logic                             pin_oe_ff;
  logic [pdm_pkg::SYNC_STAGES-1:0]  pin_sync_ff;
  logic                             gpio_in_ff;

  // full duty is only reachable through the gpio path (R8)
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      pin_o_ff  <= 1'b0;
      pin_oe_ff <= 1'b0;
    end else begin
      pin_o_ff  <= pin_modulator_select_ff ? pdm_out_ff : gpio_out_data; // R1
      pin_oe_ff <= port_two_direction;
    end
  end

  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      pin_sync_ff <= '0;
      gpio_in_ff  <= 1'b0;
    end else begin
      pin_sync_ff <= {pin_sync_ff[1:0], port_two_bit_two_pin_i};
      if (pin_sync_ff[1] == pin_sync_ff[2]) begin
        gpio_in_ff <= pin_sync_ff[2];
      end
    end
  end

  assign port_two_bit_two_pin_o  = pin_o_ff;
  assign port_two_bit_two_pin_oe = pin_oe_ff;
  assign gpio_in_data            = gpio_in_ff;

  // ----------------------------------------------------------------
  // assertions
  // ----------------------------------------------------------------
  logic [7:0] gap_ff;
  logic       gap_ok_ff;
  logic       ctl_wr;

  assign ctl_wr = wr_ok && (wr_idx == pdm_pkg::PDM_REG_CTL);

  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      gap_ff    <= 8'h00;
      gap_ok_ff <= 1'b0;
    end else if (!modulator_enable_ff || ctl_wr) begin
      gap_ff    <= 8'h00;
      gap_ok_ff <= 1'b0;
    end else if (base_tick) begin
      gap_ff    <= 8'h00;
      gap_ok_ff <= 1'b1;
    end else begin
      gap_ff <= gap_ff + 8'h01;
    end
  end

  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (rst);

  a_pin_mux_path: assert property ( // R1
    ##1 port_two_bit_two_pin_o == ($past(pin_modulator_select_ff) ?
        $past(pdm_out_ff) : $past(gpio_out_data)))
    else $error("pin does not follow mux selection");

  a_disabled_quiet: assert property ( // R2
    !modulator_enable_ff [*2] |-> !pdm_out_ff && slot_cnt_ff == 16'h0000)
    else $error("modulator active while disabled");

  a_tick_period: assert property ( // R3
    base_tick && gap_ok_ff |-> gap_ff == 8'(div_mask))
    else $error("base tick spacing wrong for divider");

  a_slot_advance: assert property ( // R4
    base_tick && !ctl_wr |=> slot_cnt_ff == $past(slot_cnt_ff) + 16'h0001)
    else $error("slot counter did not advance on tick");

  a_pulse_disjoint: assert property ( // R11
    $onehot0(pulse_vec))
    else $error("weighted pulses overlap");

  a_top_pulse_half: assert property ( // R4
    base_tick |=> pulse_vec[15] != $past(pulse_vec[15]))
    else $error("top weighted pulse not half the base rate");

  a_density_out: assert property ( // R5
    modulator_enable_ff |=>
      pdm_out_ff == |($past(density_word_ff) & $past(pulse_vec)))
    else $error("output not the included pulse combination");

  a_zero_density: assert property ( // R6
    density_word_ff == 16'h0000 [*2] |-> !pdm_out_ff)
    else $error("output high with zero density");

  a_low_byte_write: assert property ( // R7
    wr_ok && wr_idx == pdm_pkg::PDM_REG_DLO |=>
      density_word_ff[7:0] == $past(wr_data) && s_axi_bvalid)
    else $error("low density byte not stored");

  a_read_reserved: assert property ( // R9
    s_axi_rvalid && $past(rd_fire) && $past(rd_idx) == pdm_pkg::PDM_REG_MUX
      |-> (s_axi_rdata & 32'hffff_ffef) == 32'h0000_0000)
    else $error("unimplemented mux bits read nonzero");

  c_slowest_tick: cover property (
    base_tick && base_clock_divider_select_ff == 3'h7);
  c_output_high: cover property (pdm_out_ff && pin_modulator_select_ff);
  c_write_done: cover property (s_axi_bvalid && s_axi_bready);
  c_read_done: cover property (s_axi_rvalid && s_axi_rready);

endmodule

// file: pdm_pkg.sv
// package: register map, field layout and constants of the density modulator
package pdm_pkg;

  // ----------------------------------------------------------------
  // register indexes and byte addresses (byte address = 4 * index)
  // ----------------------------------------------------------------
  localparam logic [7:0] IDX_MUX  = 8'h27;
  localparam logic [7:0] IDX_DHI  = 8'h30;
  localparam logic [7:0] IDX_DLO  = 8'h31;
  localparam logic [7:0] IDX_CTL  = 8'h36;
  localparam logic [7:0] ADDR_MUX = {IDX_MUX[5:0], 2'b00};
  localparam logic [7:0] ADDR_DHI = {IDX_DHI[5:0], 2'b00};
  localparam logic [7:0] ADDR_DLO = {IDX_DLO[5:0], 2'b00};
  localparam logic [7:0] ADDR_CTL = {IDX_CTL[5:0], 2'b00};

  // ----------------------------------------------------------------
  // field positions and widths
  // ----------------------------------------------------------------
  localparam int MUX_SEL_BIT = 4;
  localparam int CTL_EN_BIT  = 4;
  localparam int SEL_W       = 3;
  localparam int PRE_W       = 7;
  localparam int DENS_W      = 16;
  localparam int SYNC_STAGES = 3;

  // ----------------------------------------------------------------
  // values after reset
  // ----------------------------------------------------------------
  localparam logic [7:0] RST_MUX = 8'h00;
  localparam logic [7:0] RST_DHI = 8'h00;
  localparam logic [7:0] RST_DLO = 8'h00;
  localparam logic [7:0] RST_CTL = 8'h00;

  // ----------------------------------------------------------------
  // bus answers and register selection
  // ----------------------------------------------------------------
  localparam logic [1:0] RESP_OKAY   = 2'b00;
  localparam logic [1:0] RESP_SLVERR = 2'b10;

  typedef enum logic [2:0] {
    PDM_REG_NONE = 3'b000,
    PDM_REG_MUX  = 3'b001,
    PDM_REG_DHI  = 3'b010,
    PDM_REG_DLO  = 3'b011,
    PDM_REG_CTL  = 3'b100
  } pdm_reg_t;

endpackage

// file: pulse_density_modulator_tb.sv
// testbench: register access and duty measurement of the density modulator
`timescale 1ns/1ps
`define CHK(got, exp) begin check_count++; if ((got) !== (exp)) begin \
  fail_count++; $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, \
  exp); end end
module pulse_density_modulator_tb;
  // ----------------------------------------------------------------
  // signals
  // ----------------------------------------------------------------
  logic        sys_clk, rst;
  logic [7:0]  awaddr, araddr;
  logic [31:0] wdata, rdata;
  logic [1:0]  bresp, rresp;
  logic        awvalid, awready, wvalid, wready, bvalid, bready;
  logic        arvalid, arready, rvalid, rready;
  logic        gpio_out, dir, gpio_in, pin_i, pin_o, pin_oe, clr;
  logic [31:0] high_cnt, rise_cnt;
  int          fail_count, check_count;

  pdm_modulator #(.ADDR_W(8)) u_dut (
    .sys_clk(sys_clk), .rst(rst), .s_axi_awaddr(awaddr),
    .s_axi_awprot(3'h0), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
    .s_axi_wdata(wdata), .s_axi_wstrb(4'hf), .s_axi_wvalid(wvalid),
    .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid),
    .s_axi_bready(bready), .s_axi_araddr(araddr), .s_axi_arprot(3'h0),
    .s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_rdata(rdata),
    .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
    .gpio_out_data(gpio_out), .port_two_direction(dir),
    .gpio_in_data(gpio_in), .port_two_bit_two_pin_i(pin_i),
    .port_two_bit_two_pin_o(pin_o), .port_two_bit_two_pin_oe(pin_oe));

  pdm_load_model u_load (.sys_clk(sys_clk), .rst(rst), .pin_o(pin_o),
    .pin_oe(pin_oe), .clr(clr), .pin_level(pin_i), .high_cnt(high_cnt),
    .rise_cnt(rise_cnt));

  initial begin
    sys_clk = 1'b0;
    forever #12.5 sys_clk = ~sys_clk;
  end

  // ----------------------------------------------------------------
  // bus tasks
  // ----------------------------------------------------------------
  task automatic wrap_up;
    $display("checks %0d failures %0d", check_count, fail_count);
    if (fail_count == 0 && check_count > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask

  task automatic hang(input bit ok);
    if (!ok) begin
      fail_count++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, 1'b0, 1'b1);
      wrap_up();
    end
  endtask

  task automatic axi_write(input logic [7:0] a, input logic [7:0] d,
                           output logic [1:0] r);
    int n;
    bit aw_ok, w_ok, b_ok;
    aw_ok = 0;
    w_ok = 0;
    b_ok = 0;
    awaddr <= a;
    wdata <= {24'h0, d};
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    for (n = 0; n < 50 && !(aw_ok && w_ok); n++) begin
      @(posedge sys_clk);
      if (!aw_ok && awready) begin
        aw_ok = 1;
        awvalid <= 1'b0;
      end
      if (!w_ok && wready) begin
        w_ok = 1;
        wvalid <= 1'b0;
      end
    end
    for (n = 0; n < 50 && !b_ok && aw_ok && w_ok; n++) begin
      @(posedge sys_clk);
      if (bvalid) begin
        b_ok = 1;
        r = bresp;
        bready <= 1'b0;
      end
    end
    // one idle edge: the next call must not raise bready in this step
    @(posedge sys_clk);
    hang(b_ok);
  endtask

  task automatic axi_read(input logic [7:0] a, output logic [31:0] d,
                          output logic [1:0] r);
    int n;
    bit ar_ok, r_ok;
    ar_ok = 0;
    r_ok = 0;
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    for (n = 0; n < 100 && !r_ok; n++) begin
      @(posedge sys_clk);
      if (!ar_ok && arready) begin
        ar_ok = 1;
        arvalid <= 1'b0;
      end else if (ar_ok && rvalid) begin
        r_ok = 1;
        d = rdata;
        r = rresp;
        rready <= 1'b0;
      end
    end
    // one idle edge: the next call must not raise rready in this step
    @(posedge sys_clk);
    hang(r_ok);
  endtask

  // ----------------------------------------------------------------
  // scenarios
  // ----------------------------------------------------------------
  task automatic test_reset_values;
    logic [31:0] d;
    logic [1:0]  r;
    axi_read(pdm_pkg::ADDR_MUX, d, r);
    `CHK(d, 32'h0)
    axi_read(pdm_pkg::ADDR_DHI, d, r);
    `CHK(d, 32'h0)
    axi_read(pdm_pkg::ADDR_DLO, d, r);
    `CHK(d, 32'h0)
    axi_read(pdm_pkg::ADDR_CTL, d, r);
    `CHK(d, 32'h0)
    axi_read(8'h00, d, r);
    `CHK(r, pdm_pkg::RESP_SLVERR)
  endtask

  task automatic test_reg_access;
    logic [31:0] d;
    logic [1:0]  r;
    axi_write(8'h04, 8'hff, r);
    `CHK(r, pdm_pkg::RESP_SLVERR)
    axi_write(pdm_pkg::ADDR_DHI, 8'ha5, r);
    `CHK(r, pdm_pkg::RESP_OKAY)
    axi_write(pdm_pkg::ADDR_DLO, 8'h5a, r);
    axi_write(pdm_pkg::ADDR_MUX, 8'hff, r);
    axi_write(pdm_pkg::ADDR_CTL, 8'hff, r);
    axi_read(pdm_pkg::ADDR_DHI, d, r);
    `CHK(d, 32'h000000a5)
    axi_read(pdm_pkg::ADDR_DLO, d, r);
    `CHK(d, 32'h0000005a)
    axi_read(pdm_pkg::ADDR_MUX, d, r);
    `CHK(d, 32'h00000010)
    axi_read(pdm_pkg::ADDR_CTL, d, r);
    `CHK(d, 32'h00000017)
  endtask

  // configures in the documented order, then counts over a whole period
  task automatic run_case(input logic en, input logic mux, input logic gp,
                          input logic [15:0] dens, input logic [2:0] sel,
                          input int cyc, input logic [31:0] eh,
                          input logic [31:0] er);
    logic [1:0] r;
    axi_write(pdm_pkg::ADDR_CTL, {3'h0, en, 1'b0, sel}, r);
    axi_write(pdm_pkg::ADDR_DHI, dens[15:8], r);
    axi_write(pdm_pkg::ADDR_DLO, dens[7:0], r);
    gpio_out <= gp;
    dir <= 1'b1;
    axi_write(pdm_pkg::ADDR_MUX, {3'h0, mux, 4'h0}, r);
    repeat (8) @(posedge sys_clk);
    clr <= 1'b1;
    @(posedge sys_clk);
    clr <= 1'b0;
    repeat (cyc) @(posedge sys_clk);
    #1;
    `CHK(high_cnt, eh)
    `CHK(rise_cnt, er)
  endtask

  task automatic test_duty;
    run_case(1, 1, 0, 16'h8000, 3'h0, 256, 128, 128);
    run_case(1, 1, 0, 16'h0800, 3'h0, 256, 8, 8);
    run_case(1, 1, 0, 16'hc000, 3'h0, 256, 192, 64);
    run_case(1, 1, 0, 16'h8000, 3'h3, 1024, 512, 64);
    run_case(1, 1, 0, 16'h8000, 3'h7, 2048, 1024, 8);
    run_case(1, 1, 0, 16'h0000, 3'h0, 256, 0, 0);
    run_case(1, 1, 0, 16'h1228, 3'h0, 65536, 32'h1228, 32'h1228);
  endtask

  task automatic test_mux_enable;
    run_case(0, 1, 1, 16'h8000, 3'h0, 256, 0, 0);
    run_case(1, 0, 1, 16'h8000, 3'h0, 256, 256, 0);
    `CHK(pin_oe, 1'b1)
    `CHK(gpio_in, 1'b1)
    run_case(1, 0, 0, 16'h8000, 3'h0, 256, 0, 0);
    `CHK(gpio_in, 1'b0)
  endtask

  initial begin
    fail_count = 0;
    check_count = 0;
    rst = 1'b1;
    {awaddr, araddr, wdata} = '0;
    {awvalid, wvalid, bready, arvalid, rready} = '0;
    {gpio_out, dir, clr} = '0;
    repeat (4) @(posedge sys_clk);
    rst <= 1'b0;
    @(posedge sys_clk);
    test_reset_values();
    test_reg_access();
    test_duty();
    test_mux_enable();
    wrap_up();
  end
endmodule
